// ==== emc_cfg.svh ====
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH

// -----------------------------------------------------------------
// register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define EMC_IDX_MODE_ONE 7'h0b
`define EMC_IDX_MODE_TWO 7'h0c
`define EMC_IDX_P1NUM 7'h27
`define EMC_IDX_P1DEN 7'h28
`define EMC_IDX_P2NUM 7'h29
`define EMC_IDX_P2DEN 7'h2a
`define EMC_IDX_STAT 7'h30

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define EMC_RST_MODE_ONE 8'h06
`define EMC_RST_MODE_TWO 8'h41
`define EMC_RST_NUM 16'h0000
`define EMC_RST_DEN 16'h003f

// -----------------------------------------------------------------
// first mode register fields
// -----------------------------------------------------------------
`define EMC_M1_SOFT_RST 7
`define EMC_M1_ZX_LPF_DIS 6
`define EMC_M1_INTEG_EN 5
`define EMC_M1_CH_SWAP 4
`define EMC_M1_ADC_PD 3
`define EMC_M1_OUT2_DIS 2
`define EMC_M1_OUT1_DIS 1
`define EMC_M1_HPF_DIS 0

// -----------------------------------------------------------------
// second mode register fields
// -----------------------------------------------------------------
`define EMC_M2_OUT2_SRC_HI 7
`define EMC_M2_OUT2_SRC_LO 6
`define EMC_M2_OUT1_SRC_HI 5
`define EMC_M2_OUT1_SRC_LO 4
`define EMC_M2_APP_RMS 3
`define EMC_M2_RMS_ZX 2
`define EMC_M2_FREQ_SEL 1

`endif

// ==== emc_mode_config.sv ====
`timescale 1ns/10ps
`include "emc_cfg.svh"

// Function
// - soft reset bit restores all defaults
// - zero-cross filter bypass bit, resets zero
// - integrator enable bit, resets zero
// - channel swap exchanges the two ADC channels
// - power-down bit stops both ADCs
// - output two disable, resets one
// - output one disable, resets one
// - high-pass filter bypass bit
// - output two source select, resets 01
// - output one source select, resets 00
// - shared bit picks apparent or current RMS
// - RMS updates follow voltage zero-crossings
// - pick bit selects period or frequency
// - output one numerator and denominator registers
// - output two numerator and denominator registers
module emc_mode_config (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire emc_pkg::emc_rate_t i_rate,
    input wire emc_pkg::emc_sample_t i_adc,
    output emc_pkg::emc_sample_t o_adc,
    output emc_pkg::emc_ctrl_t o_ctrl,
    output logic o_energy_soft_reset,
    output logic o_pulse_out_one,
    output logic o_pulse_out_two
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] addr,
                                      input logic [6:0] idx);
        addr_hit = (addr == {3'b000, idx, 2'b00});
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? wd[15:8] : old[15:8],
                   strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    // picks the rate pulse for one output
    function automatic logic pick_rate(input logic [1:0] sel,
                                       input logic app_rms,
                                       input emc_pkg::emc_rate_t r);
        pick_rate = 1'b0;
        unique case (emc_pkg::emc_src_t'(sel))
            emc_pkg::EMC_SRC_ACTIVE: pick_rate = r.active;
            emc_pkg::EMC_SRC_REACTIVE: pick_rate = r.reactive;
            emc_pkg::EMC_SRC_OTHER,
            emc_pkg::EMC_SRC_OTHER2: begin
                pick_rate = app_rms ? r.irms : r.apparent;
            end
        endcase
    endfunction

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [7:0] mode_one_q;
    logic [7:0] mode_two_q;
    logic [15:0] num_q [2];
    logic [15:0] den_q [2];
    logic [31:0] rdata_q;
    logic err_q;
    logic soft_q;

    logic access;
    logic wr_en;
    logic soft_req;
    logic setup;
    logic [31:0] rdata_d;
    logic err_d;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    // zero wait states: read data is captured in the setup cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access & err_q;
    assign wr_en = access & i_pwrite & ~err_q;
    assign o_prdata = rdata_q;

    // a write with the soft reset bit set overrides its other bits
    assign soft_req = wr_en & i_pstrb[0]
                      & addr_hit(i_paddr, `EMC_IDX_MODE_ONE)
                      & i_pwdata[`EMC_M1_SOFT_RST];

    // -------------------------------------------------------------
    // read decode
    // -------------------------------------------------------------
    logic [1:0] pend;
    logic mix_conflict;

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (addr_hit(i_paddr, `EMC_IDX_MODE_ONE)) begin
            rdata_d[7:0] = mode_one_q;
        end else if (addr_hit(i_paddr, `EMC_IDX_MODE_TWO)) begin
            rdata_d[7:0] = mode_two_q;
        end else if (addr_hit(i_paddr, `EMC_IDX_P1NUM)) begin
            rdata_d[15:0] = num_q[0];
        end else if (addr_hit(i_paddr, `EMC_IDX_P1DEN)) begin
            rdata_d[15:0] = den_q[0];
        end else if (addr_hit(i_paddr, `EMC_IDX_P2NUM)) begin
            rdata_d[15:0] = num_q[1];
        end else if (addr_hit(i_paddr, `EMC_IDX_P2DEN)) begin
            rdata_d[15:0] = den_q[1];
        end else if (addr_hit(i_paddr, `EMC_IDX_STAT)) begin
            rdata_d[2:0] = {mix_conflict, pend};
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= i_pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= err_d;
        end
    end

    // -------------------------------------------------------------
    // mode registers
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_one_q <= `EMC_RST_MODE_ONE;
            mode_two_q <= `EMC_RST_MODE_TWO;
        end else if (soft_req) begin
            mode_one_q <= `EMC_RST_MODE_ONE;
            mode_two_q <= `EMC_RST_MODE_TWO;
        end else if (wr_en && i_pstrb[0]) begin
            if (addr_hit(i_paddr, `EMC_IDX_MODE_ONE)) begin
                mode_one_q <= i_pwdata[7:0];
            end
            if (addr_hit(i_paddr, `EMC_IDX_MODE_TWO)) begin
                mode_two_q <= i_pwdata[7:0];
            end
        end
    end

    // -------------------------------------------------------------
    // scaling registers
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            num_q[0] <= `EMC_RST_NUM;
            den_q[0] <= `EMC_RST_DEN;
            num_q[1] <= `EMC_RST_NUM;
            den_q[1] <= `EMC_RST_DEN;
        end else if (soft_req) begin
            num_q[0] <= `EMC_RST_NUM;
            den_q[0] <= `EMC_RST_DEN;
            num_q[1] <= `EMC_RST_NUM;
            den_q[1] <= `EMC_RST_DEN;
        end else if (wr_en) begin
            if (addr_hit(i_paddr, `EMC_IDX_P1NUM)) begin
                num_q[0] <= merge16(num_q[0], i_pwdata, i_pstrb);
            end
            if (addr_hit(i_paddr, `EMC_IDX_P1DEN)) begin
                den_q[0] <= merge16(den_q[0], i_pwdata, i_pstrb);
            end
            if (addr_hit(i_paddr, `EMC_IDX_P2NUM)) begin
                num_q[1] <= merge16(num_q[1], i_pwdata, i_pstrb);
            end
            if (addr_hit(i_paddr, `EMC_IDX_P2DEN)) begin
                den_q[1] <= merge16(den_q[1], i_pwdata, i_pstrb);
            end
        end
    end

    // -------------------------------------------------------------
    // soft reset strobe to the measurement core
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_req;
        end
    end
    assign o_energy_soft_reset = soft_q;

    // -------------------------------------------------------------
    // static controls and channel swap
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ctrl <= '0;
        end else begin
            o_ctrl.zx_lpf_bypass <= mode_one_q[`EMC_M1_ZX_LPF_DIS];
            o_ctrl.integrator_en <= mode_one_q[`EMC_M1_INTEG_EN];
            o_ctrl.adc_power_down <= mode_one_q[`EMC_M1_ADC_PD];
            o_ctrl.hpf_bypass <= mode_one_q[`EMC_M1_HPF_DIS];
            o_ctrl.rms_on_crossing <= mode_two_q[`EMC_M2_RMS_ZX];
            o_ctrl.freq_not_period <= mode_two_q[`EMC_M2_FREQ_SEL];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_adc <= '0;
        end else if (mode_one_q[`EMC_M1_CH_SWAP]) begin
            o_adc.ch_a <= i_adc.ch_b;
            o_adc.ch_b <= i_adc.ch_a;
        end else begin
            o_adc <= i_adc;
        end
    end

    // -------------------------------------------------------------
    // pulse rate scalers
    // -------------------------------------------------------------
    // each selected rate pulse adds the numerator; every denominator
    // worth of credit gives one output pulse. credit saturates, so a
    // numerator far above the denominator with fast input loses rate.
    logic [1:0] dis;
    logic [1:0] src_pulse;
    logic [1:0] fire;
    logic [19:0] acc_q [2];
    logic [1:0] pulse_q;

    assign dis[0] = mode_one_q[`EMC_M1_OUT1_DIS];
    assign dis[1] = mode_one_q[`EMC_M1_OUT2_DIS];
    assign src_pulse[0] = pick_rate(
        mode_two_q[`EMC_M2_OUT1_SRC_HI:`EMC_M2_OUT1_SRC_LO],
        mode_two_q[`EMC_M2_APP_RMS], i_rate);
    assign src_pulse[1] = pick_rate(
        mode_two_q[`EMC_M2_OUT2_SRC_HI:`EMC_M2_OUT2_SRC_LO],
        mode_two_q[`EMC_M2_APP_RMS], i_rate);
    // both outputs on the shared pick: one apparent, other RMS is
    // impossible by construction, flagged when both use it and neither output is disabled
    assign mix_conflict = mode_two_q[`EMC_M2_OUT1_SRC_HI]
                          & mode_two_q[`EMC_M2_OUT2_SRC_HI]
                          & ~dis[0] & ~dis[1];

    for (genvar k = 0; k < 2; k++) begin : g_out
        logic [20:0] sum;
        assign fire[k] = (den_q[k] != 16'h0000)
                         && (acc_q[k] >= {4'h0, den_q[k]});
        assign pend[k] = fire[k];
        always_comb begin
            sum = {1'b0, acc_q[k]};
            if (src_pulse[k]) begin
                sum = sum + {5'h00, num_q[k]};
            end
            if (fire[k]) begin
                sum = sum - {5'h00, den_q[k]};
            end
        end
        always_ff @(posedge i_clk_sys or negedge i_resetn) begin
            if (!i_resetn) begin
                acc_q[k] <= 20'h0_0000;
            end else if (dis[k] || soft_q || den_q[k] == 16'h0000) begin
                acc_q[k] <= 20'h0_0000;
            end else if (sum[20]) begin
                acc_q[k] <= 20'hf_ffff;
            end else begin
                acc_q[k] <= sum[19:0];
            end
        end
        always_ff @(posedge i_clk_sys or negedge i_resetn) begin
            if (!i_resetn) begin
                pulse_q[k] <= 1'b0;
            end else begin
                pulse_q[k] <= fire[k] & ~dis[k];
            end
        end
    end

    assign o_pulse_out_one = pulse_q[0];
    assign o_pulse_out_two = pulse_q[1];

endmodule

// ==== emc_mode_config_chk.sv ====
`timescale 1ns/10ps
module emc_mode_config_chk (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic o_pslverr,
    input wire emc_pkg::emc_sample_t i_adc,
    input wire emc_pkg::emc_sample_t o_adc,
    input wire emc_pkg::emc_ctrl_t o_ctrl,
    input wire logic o_energy_soft_reset,
    input wire logic o_pulse_out_one,
    input wire logic o_pulse_out_two
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // ----------------------------------------
    // write decode and expected channel order
    // ----------------------------------------
    logic wr, m1, m2, mapped, swap_q;
    logic [3:0] m1_bits;
    logic [1:0] m2_bits;
    emc_pkg::emc_sample_t exp_q;
    assign wr = i_psel & i_penable & i_pwrite;
    assign m1 = wr & (i_paddr == 12'h02c) & i_pstrb[0];
    assign m2 = wr & (i_paddr == 12'h030) & i_pstrb[0];
    assign m1_bits = {i_pwdata[6], i_pwdata[5], i_pwdata[3], i_pwdata[0]};
    assign m2_bits = i_pwdata[2:1];
    assign mapped = i_paddr inside {12'h02c, 12'h030, 12'h09c, 12'h0a0,
        12'h0a4, 12'h0a8, 12'h0c0};
    // soft reset clears the swap, so track it with the same priority
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            swap_q <= 1'b0;
        end else if (m1) begin
            swap_q <= i_pwdata[4] & !i_pwdata[7];
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            exp_q <= '0;
        end else begin
            exp_q <= swap_q ? {i_adc.ch_b, i_adc.ch_a} : i_adc;
        end
    end
    a_soft_pulse: assert property (m1 & i_pwdata[7] |=>
        o_energy_soft_reset ##1 !o_energy_soft_reset)
        else $error("soft reset pulse wrong");
    a_soft_restore: assert property (m1 & i_pwdata[7] |-> ##2
        o_ctrl == 6'h00) else $error("soft reset left controls set");
    a_mode_one_ctrl: assert property (m1 & !i_pwdata[7] |-> ##2
        {o_ctrl.zx_lpf_bypass, o_ctrl.integrator_en, o_ctrl.adc_power_down,
        o_ctrl.hpf_bypass} == $past(m1_bits, 2))
        else $error("mode one controls wrong");
    a_mode_two_ctrl: assert property (m2 |-> ##2
        {o_ctrl.rms_on_crossing, o_ctrl.freq_not_period} == $past(m2_bits, 2))
        else $error("mode two controls wrong");
    a_swap_adc: assert property (o_adc == exp_q)
        else $error("channel order wrong");
    a_err_unmapped: assert property (i_psel & i_penable |->
        o_pslverr == !mapped) else $error("slave error wrong");
    a_out1_off: assert property (m1 & i_pwdata[1] |-> ##2
        !o_pulse_out_one [*2]) else $error("output one pulsed");
    a_out2_off: assert property (m1 & i_pwdata[2] |-> ##2
        !o_pulse_out_two [*2]) else $error("output two pulsed");
    c_soft: cover property (m1 & i_pwdata[7]);
    c_pulse: cover property (o_pulse_out_one & o_pulse_out_two);
    c_err: cover property (o_pslverr);
endmodule

bind emc_mode_config emc_mode_config_chk u_chk (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_pslverr(o_pslverr),
    .i_adc(i_adc),
    .o_adc(o_adc),
    .o_ctrl(o_ctrl),
    .o_energy_soft_reset(o_energy_soft_reset),
    .o_pulse_out_one(o_pulse_out_one),
    .o_pulse_out_two(o_pulse_out_two)
);

// ==== emc_mode_config_test.sv ====
`timescale 1ns/10ps
`include "emc_cfg.svh"
module emc_mode_config_test;
    logic i_clk_sys = 0, i_resetn = 0;
    logic i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, rd;
    logic [3:0] i_pstrb = '0;
    logic o_pready, o_pslverr, o_energy_soft_reset, er;
    logic o_pulse_out_one, o_pulse_out_two;
    emc_pkg::emc_rate_t i_rate = '0;
    emc_pkg::emc_sample_t i_adc = '0, o_adc;
    emc_pkg::emc_ctrl_t o_ctrl;
    int err_count = 0, checks = 0, c1, c2;
    logic [6:0] ix [6] = '{`EMC_IDX_MODE_ONE, `EMC_IDX_MODE_TWO,
        `EMC_IDX_P1NUM, `EMC_IDX_P1DEN, `EMC_IDX_P2NUM, `EMC_IDX_P2DEN};
    logic [15:0] rv [6] = '{16'h0006, 16'h0041, 16'h0000, 16'h003f,
        16'h0000, 16'h003f};
    // source table: mode two value, rate pulse, expected outputs one/two
    logic [7:0] pm [8] = '{8'h01, 8'h01, 8'h51, 8'ha1, 8'ha1, 8'hf9,
        8'hf9, 8'h81};
    logic [3:0] pr [8] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h1, 4'h1, 4'h2, 4'h8};
    logic [1:0] pe [8] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h2};

    emc_mode_config DUT (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb),
        .o_pready(o_pready),
        .o_prdata(o_prdata),
        .o_pslverr(o_pslverr),
        .i_rate(i_rate),
        .i_adc(i_adc),
        .o_adc(o_adc),
        .o_ctrl(o_ctrl),
        .o_energy_soft_reset(o_energy_soft_reset),
        .o_pulse_out_one(o_pulse_out_one),
        .o_pulse_out_two(o_pulse_out_two)
    );
    always #2 i_clk_sys = ~i_clk_sys;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [47:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ends one idle cycle after the access, so calls can follow directly
    task automatic apb(input logic wr, input logic [6:0] idx,
        input logic [31:0] wd);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {3'h0, idx, 2'h0};
        i_pwdata <= wd;
        i_pstrb <= 4'hf;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic fire(input logic [3:0] r);
        i_rate <= r;
        @(posedge i_clk_sys);
        i_rate <= 4'h0;
        repeat (4) begin
            @(posedge i_clk_sys);
            c1 += int'(o_pulse_out_one === 1'b1);
            c2 += int'(o_pulse_out_two === 1'b1);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults();
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, ix[k], 32'h0);
            chk("default", rd, {16'h0, rv[k]});
        end
        chk("ctrl default", o_ctrl, 6'h00);
    endtask
    task automatic t_scale();
        for (int k = 2; k < 6; k++) begin
            apb(1'b1, ix[k], {16'hffff, 16'h5a00 | k[15:0]});
            apb(1'b0, ix[k], 32'h0);
            chk("scale", rd, {16'h0, 16'h5a00 | k[15:0]});
        end
        apb(1'b0, 7'h10, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask
    task automatic t_mode(input logic [7:0] m1, m2, input logic [5:0] ce);
        apb(1'b1, `EMC_IDX_MODE_ONE, {24'h0, m1});
        apb(1'b1, `EMC_IDX_MODE_TWO, {24'h0, m2});
        apb(1'b0, `EMC_IDX_MODE_ONE, 32'h0);
        chk("mode one", rd, {24'h0, m1});
        apb(1'b0, `EMC_IDX_MODE_TWO, 32'h0);
        chk("mode two", rd, {24'h0, m2});
        chk("ctrl", o_ctrl, ce);
        chk("adc", o_adc, m1[4] ? {i_adc.ch_b, i_adc.ch_a} : i_adc);
    endtask
    task automatic t_pulse();
        apb(1'b1, `EMC_IDX_MODE_ONE, 32'h0);
        for (int k = 2; k < 6; k++) begin
            apb(1'b1, ix[k], 32'h1);
        end
        // the table never mixes apparent on one output with rms on the other
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `EMC_IDX_MODE_TWO, {24'h0, pm[k]});
            c1 = 0;
            c2 = 0;
            fire(pr[k]);
            chk("source one", c1, pe[k][1]);
            chk("source two", c2, pe[k][0]);
            apb(1'b0, `EMC_IDX_STAT, 32'h0);
            chk("status", rd, {29'h0, pm[k][7] & pm[k][5], 2'h0});
        end
        apb(1'b1, `EMC_IDX_MODE_TWO, 32'h01);
        apb(1'b1, `EMC_IDX_P1DEN, 32'h3);
        c1 = 0;
        c2 = 0;
        repeat (3) fire(4'h8);
        chk("ratio one", c1, 1);
        chk("ratio two", c2, 3);
        apb(1'b1, `EMC_IDX_MODE_ONE, 32'h06);
        c1 = 0;
        c2 = 0;
        repeat (3) fire(4'h8);
        chk("disabled", {c1[1:0], c2[1:0]}, 4'h0);
    endtask

    initial begin
        repeat (3000) @(posedge i_clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(posedge i_clk_sys);
        i_adc <= {24'h12_3456, 24'hab_cdef};
        t_defaults();
        t_scale();
        t_mode(8'h49, 8'h05, 6'h2e);
        t_mode(8'h36, 8'hfb, 6'h11);
        t_pulse();
        apb(1'b1, `EMC_IDX_MODE_ONE, 32'hc9);
        chk("soft strobe", o_energy_soft_reset, 1'b1);
        @(posedge i_clk_sys);
        chk("soft strobe end", o_energy_soft_reset, 1'b0);
        t_defaults();
        wrap_up();
    end
endmodule

// ==== emc_pkg.sv ====
package emc_pkg;

    typedef struct packed {
        logic zx_lpf_bypass;
        logic integrator_en;
        logic adc_power_down;
        logic hpf_bypass;
        logic rms_on_crossing;
        logic freq_not_period;
    } emc_ctrl_t;

    typedef struct packed {
        logic active;
        logic reactive;
        logic apparent;
        logic irms;
    } emc_rate_t;

    typedef struct packed {
        logic [23:0] ch_a;
        logic [23:0] ch_b;
    } emc_sample_t;

    typedef enum logic [1:0] {
        EMC_SRC_ACTIVE = 2'b00,
        EMC_SRC_REACTIVE = 2'b01,
        EMC_SRC_OTHER = 2'b10,
        EMC_SRC_OTHER2 = 2'b11
    } emc_src_t;

endpackage
